// ==== hdl/fps_sequencer.sv ====
// flyback pwm sequencer: oscillator, latch, burst, soft-start, protection
`timescale 1ns/1ps
`include "fps_regs.svh"
module fps_sequencer #(
  parameter int unsigned RESTART_CYC =
    `FPS_RESTART_MS * (`FPS_CLK_HZ / 1000),
  parameter int unsigned WAKE_CYC = `FPS_WAKE_US * (`FPS_CLK_HZ / 1000000),
  parameter int unsigned UVB_CYC = `FPS_UVB_MS * (`FPS_CLK_HZ / 1000),
  parameter int unsigned SS_STEP_CYC = `FPS_SS_STEP_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] freq_sel,
  input wire fps_pkg::fps_sense_t sense_in,
  output logic switch_drive_out,
  output logic demag_done,
  output logic [2:0] soft_level,
  output logic parking_hold,
  output fps_pkg::fps_status_t supply_status_word
);
  import fps_pkg::*;

  // synchronised comparator inputs (two stages)
  fps_sense_t sync1_r;
  fps_sense_t sen_r;
  fps_state_t state_r;
  logic [7:0] per_base;     // nominal period in cycles
  logic [7:0] per_r;        // jittered period in use
  logic [7:0] osc_cnt_r;    // oscillator phase counter
  logic osc_pulse;          // one-cycle oscillator set pulse
  logic set_pend_r;         // set pulse held for demag
  logic demag_r;            // demag seen in this cycle
  logic on_r;               // pwm latch
  logic [7:0] leb_cnt_r;    // blanking counter after turn-on
  logic sense_live;         // current sense unblanked
  logic [4:0] jit_cnt_r;    // cycles per jitter step
  logic signed [3:0] jit_off_r; // present jitter offset
  logic jit_up_r;           // jitter direction
  logic [31:0] tmr_r;       // shared state timer
  logic [2:0] step_r;       // soft-start step
  logic [31:0] uvb_r;       // undervoltage blank counter
  logic [2:0] uv_cnt_r;     // undervoltage cycle count
  logic [2:0] fbc_cnt_r;    // weak feedback current count
  logic fb_ok_r;            // feedback current seen this on-time
  logic first_done_r;       // first wake cycle finished
  logic fault_now;          // any fault this clock
  logic [2:0] cause_now;    // fault cause vector
  logic switching;          // states that switch
  logic to_idle;            // sequencer drops into idle this clock

  // input synchroniser
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1_r <= '0;
      sen_r <= '0;
    end else begin
      sync1_r <= sense_in;
      sen_r <= sync1_r;
    end
  end

  // frequency code to nominal period
  always_comb begin
    case (freq_sel)
      `FPS_FREQ_200: per_base = 8'(`FPS_PER_200);
      `FPS_FREQ_300: per_base = 8'(`FPS_PER_300);
      `FPS_FREQ_600: per_base = 8'(`FPS_PER_600);
      default: per_base = 8'(`FPS_PER_400);
    endcase
  end

  // triangular jitter of the period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      jit_cnt_r <= '0;
      jit_off_r <= '0;
      jit_up_r <= 1'b1;
    end else if (osc_pulse) begin
      if (jit_cnt_r == 5'(`FPS_JIT_CYC - 1)) begin
        jit_cnt_r <= '0;
        if (jit_up_r) begin
          if (jit_off_r == 4'sd`FPS_JIT_SPAN) begin
            jit_up_r <= 1'b0;
            jit_off_r <= jit_off_r - 4'sd1;
          end else begin
            jit_off_r <= jit_off_r + 4'sd1;
          end
        end else begin
          if (jit_off_r == -4'sd`FPS_JIT_SPAN) begin
            jit_up_r <= 1'b1;
            jit_off_r <= jit_off_r + 4'sd1;
          end else begin
            jit_off_r <= jit_off_r - 4'sd1;
          end
        end
      end else begin
        jit_cnt_r <= jit_cnt_r + 5'h01;
      end
    end
  end

  // oscillator counter, period latched each cycle
  assign switching = (state_r == FPS_ST_SOFT) || (state_r == FPS_ST_RUN) ||
                     (state_r == FPS_ST_WAKE);
  assign osc_pulse = switching && (osc_cnt_r == 8'h00);
  always_ff @(posedge clk_sys) begin
    if (rst || !switching) begin
      osc_cnt_r <= '0;
      per_r <= 8'(`FPS_PER_400);
    end else if (osc_cnt_r >= per_r - 8'h01) begin
      osc_cnt_r <= '0;
      per_r <= per_base + 8'(jit_off_r);
    end else begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end
  end

  // demag tracking and anti-ccm hold of the set pulse
  always_ff @(posedge clk_sys) begin
    if (rst || !switching) begin
      demag_r <= 1'b1;
      set_pend_r <= 1'b0;
    end else if ((osc_pulse || set_pend_r) && demag_r) begin
      demag_r <= 1'b0; // new cycle consumes demag
      set_pend_r <= 1'b0;
    end else begin
      if (sen_r.demag_seen && !on_r) demag_r <= 1'b1;
      if (osc_pulse) set_pend_r <= 1'b1;
    end
  end
  assign demag_done = demag_r;

  // leading-edge blanking counter
  always_ff @(posedge clk_sys) begin
    if (rst || !on_r) begin
      leb_cnt_r <= '0;
    end else if (leb_cnt_r != 8'(`FPS_LEB_CYC)) begin
      leb_cnt_r <= leb_cnt_r + 8'h01;
    end
  end
  assign sense_live = on_r && (leb_cnt_r == 8'(`FPS_LEB_CYC));

  // no turn-on on the clock that the sequencer drops into idle
  assign to_idle = sen_r.burst_low &&
                   ((state_r == FPS_ST_RUN) ||
                    ((state_r == FPS_ST_WAKE) && osc_pulse &&
                     (tmr_r == 32'h2)));

  // pwm latch
  always_ff @(posedge clk_sys) begin
    if (rst || !switching || fault_now || to_idle) begin
      on_r <= 1'b0;
    end else if ((osc_pulse || set_pend_r) && demag_r && !on_r) begin
      on_r <= 1'b1;
    end else if (on_r && (sen_r.ramp_trip || osc_pulse)) begin
      on_r <= 1'b0;
    end else if (sense_live && sen_r.first_overcurrent_limit_trip) begin
      on_r <= 1'b0;
    end
  end
  assign switch_drive_out = on_r;

  // fault detection causes
  always_comb begin
    cause_now = 3'h0;
    cause_now[2] = sense_live && sen_r.second_overcurrent_limit_trip;
    cause_now[1] = osc_pulse && (uv_cnt_r == 3'(`FPS_FAULT_CNT - 1)) &&
                   sen_r.uv_low && (uvb_r == 32'h0) &&
                   (state_r == FPS_ST_RUN);
    cause_now[0] = osc_pulse && (fbc_cnt_r == 3'(`FPS_FAULT_CNT - 1)) &&
                   !fb_ok_r && (state_r != FPS_ST_FAULT);
    fault_now = |cause_now;
  end

  // feedback current seen during on-time
  always_ff @(posedge clk_sys) begin
    if (rst || osc_pulse) begin
      fb_ok_r <= 1'b0;
    end else if (on_r && sen_r.fb_cur_ok) begin
      fb_ok_r <= 1'b1;
    end
  end

  // consecutive-cycle counters, checked at each cycle start
  always_ff @(posedge clk_sys) begin
    if (rst || state_r == FPS_ST_FAULT || fault_now) begin
      uv_cnt_r <= '0;
      fbc_cnt_r <= '0;
    end else if (osc_pulse) begin
      if (sen_r.uv_low && uvb_r == 32'h0 && state_r == FPS_ST_RUN)
        uv_cnt_r <= uv_cnt_r + 3'h1;
      else
        uv_cnt_r <= '0;
      if (!fb_ok_r)
        fbc_cnt_r <= fbc_cnt_r + 3'h1;
      else
        fbc_cnt_r <= '0;
    end
  end

  // main sequencer state and timer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= FPS_ST_SOFT;
      tmr_r <= '0;
      step_r <= '0;
      uvb_r <= '0;
      first_done_r <= 1'b0;
    end else if (fault_now) begin
      state_r <= FPS_ST_FAULT;
      tmr_r <= '0;
    end else begin
      if (uvb_r != 32'h0) uvb_r <= uvb_r - 32'h1;
      case (state_r)
        FPS_ST_SOFT: begin
          if (tmr_r == SS_STEP_CYC - 1) begin
            tmr_r <= '0;
            if (step_r == 3'(`FPS_SS_STEPS - 1)) begin
              state_r <= FPS_ST_RUN;
              uvb_r <= UVB_CYC;
            end else begin
              step_r <= step_r + 3'h1;
            end
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        FPS_ST_RUN: begin
          if (sen_r.burst_low) begin
            state_r <= FPS_ST_IDLE;
            tmr_r <= '0;
          end
        end
        FPS_ST_IDLE: begin
          if (tmr_r == WAKE_CYC - 1) begin
            state_r <= FPS_ST_WAKE;
            tmr_r <= '0;
            first_done_r <= 1'b0;
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        FPS_ST_WAKE: begin
          // timer counts set pulses: start, end of first, end of second
          if (osc_pulse && tmr_r == 32'h2) begin
            tmr_r <= '0;
            state_r <= sen_r.burst_low ? FPS_ST_IDLE : FPS_ST_RUN;
          end else if (osc_pulse) begin
            tmr_r <= tmr_r + 32'h1;
            if (tmr_r == 32'h1) begin
              first_done_r <= 1'b1;
            end
          end
        end
        FPS_ST_FAULT: begin
          if (tmr_r == RESTART_CYC - 1) begin
            state_r <= FPS_ST_SOFT;
            tmr_r <= '0;
            step_r <= '0;
          end else begin
            tmr_r <= tmr_r + 32'h1;
          end
        end
        default: begin
          state_r <= FPS_ST_SOFT;
          tmr_r <= '0;
        end
      endcase
    end
  end

  // parking hold released after first wake cycle
  assign parking_hold = (state_r == FPS_ST_IDLE) ||
                        ((state_r == FPS_ST_WAKE) && !first_done_r);
  assign soft_level = step_r;

  // status word, fault flag and cause
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      supply_status_word <= '0;
    end else begin
      supply_status_word.idle <= (state_r == FPS_ST_IDLE);
      supply_status_word.soft_start <= (state_r == FPS_ST_SOFT);
      if (fault_now) begin
        supply_status_word.converter_fault_flag <= 1'b1;
        supply_status_word.fault_cause <= cause_now;
      end else if (state_r == FPS_ST_FAULT && tmr_r == RESTART_CYC - 1) begin
        supply_status_word.converter_fault_flag <= 1'b0;
        supply_status_word.fault_cause <= '0;
      end
    end
  end
endmodule

// ==== hdl/fps_regs.svh ====
// timing counts and field encodings for the flyback pwm sequencer
`ifndef FPS_REGS_SVH
`define FPS_REGS_SVH
`define FPS_CLK_HZ 10000000
// oscillator period in clk_sys cycles per frequency code
`define FPS_FREQ_400 2'h0
`define FPS_FREQ_200 2'h1
`define FPS_FREQ_300 2'h2
`define FPS_FREQ_600 2'h3
`define FPS_PER_400 (`FPS_CLK_HZ / 400000)
`define FPS_PER_200 (`FPS_CLK_HZ / 200000)
`define FPS_PER_300 (`FPS_CLK_HZ / 300000)
`define FPS_PER_600 (`FPS_CLK_HZ / 600000)
// jitter: +/- span in cycles, oscillator cycles per step
`define FPS_JIT_SPAN 2
`define FPS_JIT_CYC 16
// soft-start: 8 steps of 1 ms
`define FPS_SS_STEPS 8
`define FPS_SS_STEP_MS 1
`define FPS_SS_STEP_CYC (`FPS_CLK_HZ / 1000 * `FPS_SS_STEP_MS)
// blanking, restart, wake and undervoltage blanking times, fault cycle count, step width
`define FPS_LEB_NS 300
`define FPS_LEB_CYC ((`FPS_LEB_NS * (`FPS_CLK_HZ / 1000000) + 999) / 1000)
`define FPS_RESTART_MS 100
`define FPS_WAKE_US 1000
`define FPS_UVB_MS 5
`define FPS_FAULT_CNT 4
`define FPS_STEP_W 3
`endif

// ==== hdl/fps_pkg.sv ====
// types shared by the flyback pwm sequencer
package fps_pkg;
  typedef enum logic [2:0] {
    FPS_ST_SOFT, FPS_ST_RUN, FPS_ST_IDLE, FPS_ST_WAKE, FPS_ST_FAULT
  } fps_state_t;
  // comparator inputs from the analog side
  typedef struct packed {
    logic ramp_trip;     // ramp reached control level
    logic first_overcurrent_limit_trip;     // first_overcurrent_limit exceeded
    logic second_overcurrent_limit_trip;     // second_overcurrent_limit exceeded
    logic burst_low;     // comp below burst_entry_level
    logic uv_low;        // sampled feedback below uv threshold
    logic fb_cur_ok;     // feedback pin current above minimum
    logic demag_seen;    // demagnetization detected
  } fps_sense_t;
  // status presented to software
  typedef struct packed {
    logic converter_fault_flag;
    logic [2:0] fault_cause; // second_overcurrent_limit, uv, open winding
    logic idle;
    logic soft_start;
  } fps_status_t;
endpackage

// ==== verification/fps_sequencer_sva.sv ====
// checker for the flyback pwm sequencer ports
`timescale 1ns/1ps
module fps_sequencer_sva #(
  parameter int unsigned RESTART_CYC = 200
) (
  input wire logic clk_sys,
  input wire logic rst,
  input fps_pkg::fps_sense_t sense_in,
  input wire logic switch_drive_out,
  input wire logic demag_done,
  input wire logic [2:0] soft_level,
  input wire logic parking_hold,
  input fps_pkg::fps_status_t supply_status_word
);
  import fps_pkg::*;
  fps_status_t s; // short alias of the status word
  logic flg; // fault flag alias
  logic [31:0] fcnt_r; // cycles the flag has stood
  assign s = supply_status_word;
  assign flg = supply_status_word.converter_fault_flag;
  // count consecutive flag-high cycles
  always_ff @(posedge clk_sys) begin
    if (rst || !flg)
      fcnt_r <= 32'h0;
    else
      fcnt_r <= fcnt_r + 32'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_idle_off;
    s.idle && $past(s.idle) |-> !switch_drive_out;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("drive on in idle");
  property p_idle_park;
    s.idle |-> parking_hold;
  endproperty
  a_idle_park: assert property (p_idle_park)
    else $error("no park hold");
  property p_flag_off;
    flg && $past(flg) |-> !switch_drive_out;
  endproperty
  a_flag_off: assert property (p_flag_off)
    else $error("drive in fault");
  property p_flag_len;
    $fell(flg) |-> fcnt_r >= RESTART_CYC - 1 && fcnt_r <= RESTART_CYC + 1;
  endproperty
  a_flag_len: assert property (p_flag_len)
    else $error("flag length");
  property p_flag_soft;
    $fell(flg) |-> ##[0:2] s.soft_start;
  endproperty
  a_flag_soft: assert property (p_flag_soft)
    else $error("no soft start");
  property p_flag_cause;
    $rose(flg) |-> s.fault_cause != 3'h0;
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("no cause");
  // a drop into idle may cut the on-time, blanking covers three clocks
  property p_leb;
    $rose(switch_drive_out) |=>
      (switch_drive_out || flg || parking_hold) [*3];
  endproperty
  a_leb: assert property (p_leb)
    else $error("cut inside blanking");
  property p_first_overcurrent_limit_cut;
    not ((switch_drive_out && sense_in.first_overcurrent_limit_trip) [*7]);
  endproperty
  a_first_overcurrent_limit_cut: assert property (p_first_overcurrent_limit_cut)
    else $error("no ocp cut");
  property p_demag;
    $rose(switch_drive_out) |-> ##[0:1] !demag_done;
  endproperty
  a_demag: assert property (p_demag)
    else $error("demag not cleared");
  property p_ss_step;
    s.soft_start && $past(s.soft_start) && $changed(soft_level) |->
      soft_level == $past(soft_level) + 3'h1 ##1
      ($stable(soft_level) || !s.soft_start) [*8];
  endproperty
  a_ss_step: assert property (p_ss_step)
    else $error("soft step");
endmodule
bind fps_sequencer fps_sequencer_sva #(.RESTART_CYC(RESTART_CYC))
  fps_sequencer_sva_i (.clk_sys(clk_sys), .rst(rst), .sense_in(sense_in),
  .switch_drive_out(switch_drive_out), .demag_done(demag_done),
  .soft_level(soft_level), .parking_hold(parking_hold),
  .supply_status_word(supply_status_word));

// ==== verification/fps_flyback_model.sv ====
// model of the external switch, shunt and transformer
`timescale 1ns/1ps
module fps_flyback_model (
  input wire logic clk_sys,
  input wire logic switch_drive_out,
  input wire logic [3:0] on_len,
  input wire logic first_overcurrent_limit,
  input wire logic second_overcurrent_limit,
  input wire logic uv,
  input wire logic fb_bad,
  input wire logic burst,
  output fps_pkg::fps_sense_t sense_in
);
  import fps_pkg::*;
  logic [3:0] on_cnt = 4'h0; // cycles since turn-on
  logic [3:0] off_cnt = 4'h0; // cycles since turn-off
  initial sense_in = '0;
  // comparators settle after the falling edge
  always @(negedge clk_sys) begin
    on_cnt <= switch_drive_out ? on_cnt + 4'h1 : 4'h0;
    off_cnt <= switch_drive_out ? 4'h0 : off_cnt + {3'h0, off_cnt != 4'hF};
    sense_in.ramp_trip <= switch_drive_out && on_cnt >= on_len;
    sense_in.first_overcurrent_limit_trip <= switch_drive_out && first_overcurrent_limit;
    sense_in.second_overcurrent_limit_trip <= switch_drive_out && second_overcurrent_limit;
    sense_in.fb_cur_ok <= switch_drive_out && !fb_bad;
    // secondary current ends three cycles after turn-off
    sense_in.demag_seen <= !switch_drive_out && off_cnt >= 4'h3;
    sense_in.burst_low <= burst;
    sense_in.uv_low <= uv;
  end
endmodule

// ==== verification/fps_sequencer_tb.sv ====
// self-checking bench for the flyback pwm sequencer
`timescale 1ns/1ps
`include "fps_regs.svh"
module fps_sequencer_tb;
  import fps_pkg::*;
  localparam int unsigned RC = 200; // shortened restart time
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] freq_sel = 2'h0;
  logic [3:0] on_len = 4'h5; // ramp length in the model
  logic first_overcurrent_limit = 1'b0;
  logic second_overcurrent_limit = 1'b0;
  logic uv = 1'b0;
  logic fb_bad = 1'b0;
  logic burst = 1'b0;
  logic [16:0] lfsr = 17'h167B7; // random source
  fps_sense_t sense_in;
  fps_status_t st;
  logic drv;
  logic pdrv = 1'b0; // drive at last look
  logic pflg = 1'b0; // flag at last look
  int cyc = 0;
  int last_r = 0; // cycle of last turn-on
  int errors = 0;
  int cmp_count = 0;
  int per_q[$]; // expected periods
  logic [2:0] cause_q[$]; // expected fault causes
  int per[4] = '{`FPS_PER_400, `FPS_PER_200, `FPS_PER_300, `FPS_PER_600};
  fps_sequencer #(.RESTART_CYC(RC), .WAKE_CYC(100), .UVB_CYC(100),
    .SS_STEP_CYC(50)) fps_sequencer_i (.clk_sys(clk_sys), .rst(rst),
    .freq_sel(freq_sel), .sense_in(sense_in), .switch_drive_out(drv),
    .demag_done(), .soft_level(), .parking_hold(),
    .supply_status_word(st));
  fps_flyback_model fps_flyback_model_i (.clk_sys(clk_sys),
    .switch_drive_out(drv), .on_len(on_len), .first_overcurrent_limit(first_overcurrent_limit), .second_overcurrent_limit(second_overcurrent_limit),
    .uv(uv), .fb_bad(fb_bad), .burst(burst), .sense_in(sense_in));
  initial forever #50 clk_sys = ~clk_sys;
  function automatic logic [16:0] nxt(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic end_sim;
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_v(input logic [2:0] got, input logic [2:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // period within jitter span of its set value
  task automatic cmp_p(input int got, input int exp);
    cmp_count++;
    if (got < exp - `FPS_JIT_SPAN || got > exp + `FPS_JIT_SPAN) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for a status bit (5 flag, 1 idle, 0 soft)
  task automatic wait_st(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (st[b] !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (st[b] !== v) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, st[b], v);
      end_sim;
    end
  endtask
  // monitor: period of turn-ons, cause of each fault
  always @(negedge clk_sys) begin
    cyc <= cyc + 1;
    pdrv <= drv;
    pflg <= st.converter_fault_flag;
    if (drv && !pdrv) begin
      if (per_q.size() > 0 && last_r > 0)
        cmp_p(cyc - last_r, per_q.pop_front());
      last_r <= cyc;
    end
    if (st.converter_fault_flag && !pflg) begin
      if (cause_q.size() > 0)
        cmp_v(st.fault_cause, cause_q.pop_front());
      else
        cmp_v({2'h0, st.converter_fault_flag}, 3'h0);
    end
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    // every frequency code with a random ramp length
    for (int k = 0; k < 4; k++) begin
      lfsr = nxt(lfsr);
      on_len = 4'h4 + {3'h0, lfsr[0]};
      freq_sel = k[1:0];
      repeat (600) @(negedge clk_sys);
      per_q.push_back(per[k]);
      repeat (60) @(negedge clk_sys);
    end
    // current limit against a long ramp
    on_len = 4'hF;
    first_overcurrent_limit = 1'b1;
    repeat (200) @(negedge clk_sys);
    first_overcurrent_limit = 1'b0;
    on_len = 4'h4;
    // light load: idle, wakes, resume
    burst = 1'b1;
    wait_st(1, 1'b1, 300);
    repeat (250) @(negedge clk_sys);
    burst = 1'b0;
    wait_st(1, 1'b0, 300);
    // load is back: the wake decision must keep it switching
    repeat (200) @(negedge clk_sys);
    cmp_v({2'h0, st.idle}, 3'h0);
    // each fault kind in turn, then restart
    for (int k = 0; k < 3; k++) begin
      cause_q.push_back(3'h4 >> k);
      {second_overcurrent_limit, uv, fb_bad} = 3'h4 >> k;
      if (k == 1) begin
        repeat (60) @(negedge clk_sys);
        cmp_v({2'h0, st.converter_fault_flag}, 3'h0);
      end
      wait_st(5, 1'b1, 1000);
      {second_overcurrent_limit, uv, fb_bad} = 3'h0;
      wait_st(5, 1'b0, RC + 10);
      wait_st(0, 1'b1, 5);
      wait_st(0, 1'b0, 600);
    end
    // short undervoltage runs never reach four cycles
    repeat (120) @(negedge clk_sys);
    repeat (3) begin
      uv = 1'b1;
      repeat (40) @(negedge clk_sys);
      uv = 1'b0;
      repeat (20) @(negedge clk_sys);
    end
    cmp_v({2'h0, st.converter_fault_flag}, 3'h0);
    end_sim;
  end
endmodule
